// ### logic/uep_ctrl.sv
// Behaviour
// - Writing 1 to serviced-setup-end clears setup-end; nothing else is stored.
// - Both service command bits always read back as zero.
// - Out-packet-ready clears only through a firmware serviced-out write of 1.
// - Firmware sets send-stall; hardware clears it once STALL is sent.
// - Setup-end sets when a control transfer ends before data-end was written.
// - Hardware clears data-end by itself when the control transfer completes.
// - Sent-stall sets after a STALL handshake on endpoint 0.
// - In-packet-ready clears with interrupt on transmit or overwrite by SETUP/OUT.
// - A received endpoint 0 packet sets out-packet-ready and raises an interrupt.
// - Byte count bits 6:0 give received bytes, valid while out-packet-ready.
// - Byte count bit 7 reads zero and ignores writes.
// - The index register selects which endpoint register set is visible.
// - Split mode gives an endpoint both IN and OUT pipes.
// - Without split, the direction bit picks IN or OUT only.
// - A disabled endpoint ignores all traffic, with no handshake or STALL.
// - All endpoints come up enabled after reset.
// - An IN token on endpoint 0 gets NAK while in-packet-ready is 0.
`timescale 1ns/100ps
`include "uep_consts.svh"
module uep_ctrl import uep_pkg::*; (
	input wire logic SYS_CLK_IN,             // 100 MHz system clock
	input wire logic SRST_IN,                // Synchronous reset, high
	input wire logic WB_CYC_IN,              // Wishbone cycle
	input wire logic WB_STB_IN,              // Wishbone strobe
	input wire logic WB_WE_IN,               // Wishbone write enable
	input wire logic [6:0] WB_ADR_IN,        // Wishbone byte address
	input wire logic [3:0] WB_SEL_IN,        // Wishbone byte selects
	input wire logic [31:0] WB_DAT_IN,       // Wishbone write data
	output logic [31:0] WB_DAT_OUT,          // Wishbone read data
	output logic WB_ACK_OUT,                 // Wishbone acknowledge
	input wire logic USB_SETUP_TOK_IN, // SETUP token on endpoint 0
	input wire logic USB_IN_TOK_IN, // IN token on endpoint 0
	input wire logic USB_OUT_TOK_IN, // OUT token on endpoint 0
	input wire logic USB_RX_DONE_IN, // Endpoint 0 packet received
	input wire logic [6:0] USB_RX_CNT_IN, // Received byte count
	input wire logic USB_TX_DONE_IN, // Endpoint 0 IN packet sent
	input wire logic USB_STALL_SENT_IN, // Endpoint 0 STALL sent
	input wire logic USB_XFER_DONE_IN, // Control transfer complete
	output logic EP0_IRQ_OUT,                // Endpoint 0 interrupt pulse
	output logic EP0_IN_NAK_OUT,             // NAK the next IN token
	output logic EP0_STALL_REQ_OUT,          // Send STALL on endpoint 0
	output logic [3:1] EP_ENABLE_OUT,        // Endpoint 1-3 respond enables
	output logic [3:1] EP_IN_PIPE_OUT,       // Endpoint 1-3 IN pipe active
	output logic [3:1] EP_OUT_PIPE_OUT       // Endpoint 1-3 OUT pipe active
);
	uep_top_type s_ff;
	uep_top_type nxt_s;
	uep_ep0_if ep0();
	uep_reg_type reg_sel;
	logic req;
	logic wr_go;
	logic [7:0] wd;
	logic [1:0] ep;
	logic [7:0] cfg_rd;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Endpoint 0 and the 1-3 sets sit at separate offsets; only the indexed set decodes
	function automatic uep_reg_type reg_decode(input logic [4:0] word, input logic [3:0] idx);
		uep_reg_type r;
		r = UEP_REG_NONE;
		if (word == `UEP_OFF_INDEX) begin
			r = UEP_REG_INDEX;
		end else if (word == `UEP_OFF_ENABLE) begin
			r = UEP_REG_ENABLE;
		end else if (idx == 4'h0 && word == `UEP_OFF_EP0_CTRL) begin
			r = UEP_REG_EP0_CTRL;
		end else if (idx == 4'h0 && word == `UEP_OFF_EP0_COUNT) begin
			r = UEP_REG_EP0_COUNT;
		end else if (idx >= 4'h1 && idx <= 4'h3 && word == `UEP_OFF_EPCFG) begin
			r = UEP_REG_EPCFG;
		end
		return r;
	endfunction

	// Pipe activity from enable, split and direction
	function automatic logic [3:1] pipe_on(input logic [3:1] en, input logic [3:1] spl,
		input logic [3:1] dir);
		return en & (spl | dir);
	endfunction

	// ----------------------------------------
	// Endpoint 0 flag engine
	// ----------------------------------------
	uep_ep0_flags u_flags (
		.clk_in(SYS_CLK_IN),
		.srst_in(SRST_IN),
		.ep0(ep0.flags),
		.setup_tok_in(USB_SETUP_TOK_IN),
		.in_tok_in(USB_IN_TOK_IN),
		.out_tok_in(USB_OUT_TOK_IN),
		.rx_done_in(USB_RX_DONE_IN),
		.rx_cnt_in(USB_RX_CNT_IN),
		.tx_done_in(USB_TX_DONE_IN),
		.stall_sent_in(USB_STALL_SENT_IN),
		.xfer_done_in(USB_XFER_DONE_IN)
	);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign req = WB_CYC_IN & WB_STB_IN;
	assign reg_sel = reg_decode(WB_ADR_IN[6:2], s_ff.index);
	assign wd = WB_DAT_IN[7:0];
	// Writes land on the edge where ack is seen high, as the master expects
	assign wr_go = req & WB_WE_IN & WB_SEL_IN[0] & s_ff.ack;
	assign ep = s_ff.index[1:0];
	assign ep0.wr_stb = wr_go && (reg_sel == UEP_REG_EP0_CTRL);
	assign ep0.wr_data = wd;

	always_comb begin
		cfg_rd = 8'h00;
		if (ep != 2'h0) begin
			cfg_rd[`UEP_B_SPLIT] = s_ff.split[ep];
			cfg_rd[`UEP_B_DIR_SEL] = s_ff.dir_sel[ep];
		end
	end

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	always_comb begin
		nxt_s = s_ff;
		// One-cycle ack; dropped in the cycle after it was given
		nxt_s.ack = req & ~s_ff.ack;
		nxt_s.rdata = 8'h00;
		if (req && !s_ff.ack && !WB_WE_IN) begin
			unique case (reg_sel)
				UEP_REG_INDEX: begin
					nxt_s.rdata = {4'h0, s_ff.index};
				end
				UEP_REG_EP0_CTRL: begin
					nxt_s.rdata = ep0.csr;
				end
				UEP_REG_EP0_COUNT: begin
					nxt_s.rdata = {1'b0, ep0.cnt};
				end
				UEP_REG_EPCFG: begin
					nxt_s.rdata = cfg_rd;
				end
				UEP_REG_ENABLE: begin
					nxt_s.rdata = {`UEP_ENABLE_FILL, s_ff.enable, 1'b1};
				end
				UEP_REG_NONE: begin
					nxt_s.rdata = 8'h00;
				end
			endcase
		end
		if (wr_go) begin
			unique case (reg_sel)
				UEP_REG_INDEX: begin
					nxt_s.index = wd[3:0];
				end
				UEP_REG_EPCFG: begin
					nxt_s.split[ep] = wd[`UEP_B_SPLIT];
					nxt_s.dir_sel[ep] = wd[`UEP_B_DIR_SEL];
				end
				UEP_REG_ENABLE: begin
					nxt_s.enable = wd[3:1];
				end
				UEP_REG_EP0_CTRL, UEP_REG_EP0_COUNT, UEP_REG_NONE: begin
					// Flags live in the engine; byte count ignores writes
					nxt_s.index = s_ff.index;
				end
			endcase
		end
		// Outputs are registered copies so every port leaves a flip-flop
		nxt_s.irq = ep0.irq;
		nxt_s.in_nak = ~ep0.csr[`UEP_B_IN_READY];
		nxt_s.stall_req = ep0.csr[`UEP_B_SEND_STALL];
		nxt_s.in_pipe = pipe_on(nxt_s.enable, nxt_s.split, nxt_s.dir_sel);
		nxt_s.out_pipe = pipe_on(nxt_s.enable, nxt_s.split, ~nxt_s.dir_sel);
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (SRST_IN) begin
			s_ff <= '0;
			s_ff.index <= `UEP_RST_INDEX;
			s_ff.enable <= `UEP_RST_ENABLE;
			s_ff.split <= `UEP_RST_EPCFG;
			s_ff.dir_sel <= `UEP_RST_EPCFG;
			s_ff.in_nak <= 1'b1;
			// Pipes leave reset already matching the reset enables and directions
			s_ff.out_pipe <= `UEP_RST_ENABLE;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign WB_ACK_OUT = s_ff.ack;
	assign WB_DAT_OUT = {24'h000000, s_ff.rdata};
	assign EP0_IRQ_OUT = s_ff.irq;
	assign EP0_IN_NAK_OUT = s_ff.in_nak;
	assign EP0_STALL_REQ_OUT = s_ff.stall_req;
	assign EP_ENABLE_OUT = s_ff.enable;
	assign EP_IN_PIPE_OUT = s_ff.in_pipe;
	assign EP_OUT_PIPE_OUT = s_ff.out_pipe;
endmodule

// ### logic/uep_consts.svh
`ifndef UEP_CONSTS_SVH
`define UEP_CONSTS_SVH

// ----------------------------------------
// Register indexes (byte address = index * 4)
// ----------------------------------------
`define UEP_OFF_INDEX 5'h0e
`define UEP_OFF_EP0_CTRL 5'h11
`define UEP_OFF_EPCFG 5'h12
`define UEP_OFF_EP0_COUNT 5'h16
`define UEP_OFF_ENABLE 5'h1e

// ----------------------------------------
// Endpoint 0 control/status fields
// ----------------------------------------
`define UEP_B_SVC_SETUP_END 7
`define UEP_B_SVC_OUT 6
`define UEP_B_SEND_STALL 5
`define UEP_B_SETUP_END 4
`define UEP_B_DATA_END 3
`define UEP_B_SENT_STALL 2
`define UEP_B_IN_READY 1
`define UEP_B_OUT_READY 0

// ----------------------------------------
// Endpoint 1-3 configuration fields
// ----------------------------------------
`define UEP_B_SPLIT 2
`define UEP_B_DIR_SEL 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UEP_RST_EP0_CTRL 8'h00
`define UEP_RST_EP0_COUNT 7'h00
`define UEP_RST_INDEX 4'h0
`define UEP_RST_ENABLE 3'h7
`define UEP_RST_EPCFG 3'h0
`define UEP_ENABLE_FILL 4'hf

`endif

// ### logic/uep_pkg.sv
package uep_pkg;

	typedef enum logic [1:0] {UEP_IDLE, UEP_TX_MODE, UEP_RX_MODE} uep_mode_type;

	typedef enum logic [2:0] {
		UEP_REG_NONE,
		UEP_REG_INDEX,
		UEP_REG_EP0_CTRL,
		UEP_REG_EP0_COUNT,
		UEP_REG_EPCFG,
		UEP_REG_ENABLE
	} uep_reg_type;

	typedef struct packed {
		uep_mode_type mode;
		logic setup_end;
		logic data_end;
		logic send_stall;
		logic sent_stall;
		logic in_ready;
		logic out_ready;
		logic [6:0] cnt;
		logic irq;
	} uep_flags_type;

	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
		logic [3:0] index;
		logic [3:1] enable;
		logic [3:1] split;
		logic [3:1] dir_sel;
		logic irq;
		logic in_nak;
		logic stall_req;
		logic [3:1] in_pipe;
		logic [3:1] out_pipe;
	} uep_top_type;

endpackage

// ### logic/uep_ep0_if.sv
`timescale 1ns/100ps
interface uep_ep0_if;
	logic wr_stb;
	logic [7:0] wr_data;
	logic [7:0] csr;
	logic [6:0] cnt;
	logic irq;

	modport regs (output wr_stb, output wr_data, input csr, input cnt, input irq);
	modport flags (input wr_stb, input wr_data, output csr, output cnt, output irq);
endinterface

// ### logic/uep_ep0_flags.sv
`timescale 1ns/100ps
`include "uep_consts.svh"
module uep_ep0_flags import uep_pkg::*; (
	input wire logic clk_in,          // System clock
	input wire logic srst_in,         // Synchronous reset
	uep_ep0_if.flags ep0,             // Firmware side
	input wire logic setup_tok_in,    // SETUP token on endpoint 0
	input wire logic in_tok_in,       // IN token on endpoint 0
	input wire logic out_tok_in,      // OUT token on endpoint 0
	input wire logic rx_done_in,      // Data packet loaded into FIFO
	input wire logic [6:0] rx_cnt_in, // Bytes in that packet
	input wire logic tx_done_in,      // IN packet transmitted
	input wire logic stall_sent_in,   // STALL handshake transmitted
	input wire logic xfer_done_in     // Control transfer complete
);
	uep_flags_type s_ff;
	uep_flags_type nxt_s;
	logic early_end;

	// ----------------------------------------
	// Flag engine
	// ----------------------------------------
	always_comb begin
		nxt_s = s_ff;
		nxt_s.irq = 1'b0;
		early_end = 1'b0;
		// Firmware commands first so that a hardware set in the same cycle wins
		if (ep0.wr_stb) begin
			if (ep0.wr_data[`UEP_B_SVC_SETUP_END]) begin
				nxt_s.setup_end = 1'b0;
			end
			if (ep0.wr_data[`UEP_B_SVC_OUT]) begin
				nxt_s.out_ready = 1'b0;
			end
			if (ep0.wr_data[`UEP_B_SEND_STALL]) begin
				nxt_s.send_stall = 1'b1;
			end
			if (ep0.wr_data[`UEP_B_DATA_END]) begin
				nxt_s.data_end = 1'b1;
			end
			if (!ep0.wr_data[`UEP_B_SENT_STALL]) begin
				nxt_s.sent_stall = 1'b0;
			end
			if (ep0.wr_data[`UEP_B_IN_READY]) begin
				nxt_s.in_ready = 1'b1;
			end
		end
		// A token against the current direction ends the transfer early
		if (setup_tok_in) begin
			early_end = (s_ff.mode != UEP_IDLE);
			nxt_s.mode = UEP_IDLE;
		end else if (in_tok_in) begin
			early_end = (s_ff.mode == UEP_RX_MODE);
			nxt_s.mode = UEP_TX_MODE;
		end else if (out_tok_in) begin
			early_end = (s_ff.mode == UEP_TX_MODE);
			nxt_s.mode = UEP_RX_MODE;
		end
		if (early_end && !s_ff.data_end) begin
			nxt_s.setup_end = 1'b1;
			nxt_s.irq = 1'b1;
		end
		if (rx_done_in) begin
			nxt_s.out_ready = 1'b1;
			nxt_s.cnt = rx_cnt_in;
			nxt_s.irq = 1'b1;
			// Incoming data overwrites a loaded IN packet
			if (s_ff.in_ready) begin
				nxt_s.in_ready = 1'b0;
			end
		end
		if (tx_done_in && s_ff.in_ready) begin
			nxt_s.in_ready = 1'b0;
			nxt_s.irq = 1'b1;
		end
		if (stall_sent_in) begin
			nxt_s.send_stall = 1'b0;
			nxt_s.sent_stall = 1'b1;
			nxt_s.irq = 1'b1;
		end
		if (xfer_done_in) begin
			nxt_s.data_end = 1'b0;
			nxt_s.mode = UEP_IDLE;
			nxt_s.irq = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Command bits are not stored, so they read back as zero
	assign ep0.csr = {2'b00, s_ff.send_stall, s_ff.setup_end, s_ff.data_end,
		s_ff.sent_stall, s_ff.in_ready, s_ff.out_ready};
	assign ep0.cnt = s_ff.cnt;
	assign ep0.irq = s_ff.irq;
endmodule

// ### tb/uep_ctrl_asserts.sv
`timescale 1ns/100ps
module uep_ctrl_asserts (
	input wire logic SYS_CLK_IN, // Clock
	input wire logic SRST_IN, // Reset
	input wire logic WB_CYC_IN, // Cycle
	input wire logic WB_STB_IN, // Strobe
	input wire logic WB_ACK_OUT, // Acknowledge
	input wire logic USB_SETUP_TOK_IN, // SETUP token
	input wire logic USB_IN_TOK_IN, // IN token
	input wire logic USB_OUT_TOK_IN, // OUT token
	input wire logic USB_RX_DONE_IN, // Packet received
	input wire logic USB_TX_DONE_IN, // Packet sent
	input wire logic USB_STALL_SENT_IN, // STALL sent
	input wire logic USB_XFER_DONE_IN, // Transfer done
	input wire logic EP0_IRQ_OUT, // Interrupt pulse
	input wire logic EP0_STALL_REQ_OUT, // Stall request
	input wire logic [3:1] EP_ENABLE_OUT, // Enables
	input wire logic [3:1] EP_IN_PIPE_OUT, // IN pipes
	input wire logic [3:1] EP_OUT_PIPE_OUT // OUT pipes
);
	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (SRST_IN);
	logic any_ev;
	assign any_ev = USB_SETUP_TOK_IN | USB_IN_TOK_IN | USB_OUT_TOK_IN | USB_RX_DONE_IN
		| USB_TX_DONE_IN | USB_STALL_SENT_IN | USB_XFER_DONE_IN;
	a_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
		else $error("request not acknowledged");
	a_rx_irq: assert property (USB_RX_DONE_IN |-> ##2 EP0_IRQ_OUT)
		else $error("no interrupt after receive");
	a_stall_irq: assert property (USB_STALL_SENT_IN |-> ##2 EP0_IRQ_OUT)
		else $error("no interrupt after stall");
	a_stall_clear: assert property (USB_STALL_SENT_IN |-> ##2 !EP0_STALL_REQ_OUT)
		else $error("stall request kept after stall");
	a_xfer_irq: assert property (USB_XFER_DONE_IN |-> ##2 EP0_IRQ_OUT)
		else $error("no interrupt at transfer end");
	a_irq_cause: assert property (EP0_IRQ_OUT |-> $past(any_ev, 2))
		else $error("interrupt without event");
	a_rst_enable: assert property ($fell(SRST_IN) |->
		EP_ENABLE_OUT == 3'h7 && EP_OUT_PIPE_OUT == 3'h7)
		else $error("endpoints not enabled after reset");
	a_pipe_map: assert property ((EP_IN_PIPE_OUT | EP_OUT_PIPE_OUT) == EP_ENABLE_OUT)
		else $error("pipe does not follow enable");
endmodule
bind uep_ctrl uep_ctrl_asserts i_chk (.*);

// ### tb/uep_host_model.sv
`timescale 1ns/100ps
module uep_host_model (
	input wire logic clk_in, // System clock
	output logic [6:0] ev_out, // setup,in,out,rx,tx,stall,xfer
	output logic [6:0] cnt_out // Received byte count
);
	initial begin
		ev_out = 7'h00;
		cnt_out = 7'h00;
	end
	// One-cycle event; the count is garbled once its pulse is over
	task send(input logic [6:0] m, input logic [6:0] n);
		@(posedge clk_in);
		ev_out <= m;
		cnt_out <= n;
		@(posedge clk_in);
		ev_out <= 7'h00;
		cnt_out <= ~n;
	endtask
endmodule

// ### tb/test_uep_ctrl.sv
`timescale 1ns/100ps
module test_uep_ctrl;
	logic clk, rst, cyc, stb, we, ack, irq, nak, sreq;
	logic [6:0] adr, ev, cnt;
	logic [3:0] sel;
	logic [31:0] dat, rdat;
	logic [3:1] en, ip, op;
	logic [7:0] q;
	int error_cnt, tests_run;
	uep_host_model i_host (.clk_in(clk), .ev_out(ev), .cnt_out(cnt));
	uep_ctrl i_dut (.SYS_CLK_IN(clk), .SRST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat),
		.WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .USB_SETUP_TOK_IN(ev[6]),
		.USB_IN_TOK_IN(ev[5]), .USB_OUT_TOK_IN(ev[4]), .USB_RX_DONE_IN(ev[3]),
		.USB_RX_CNT_IN(cnt), .USB_TX_DONE_IN(ev[2]), .USB_STALL_SENT_IN(ev[1]),
		.USB_XFER_DONE_IN(ev[0]), .EP0_IRQ_OUT(irq), .EP0_IN_NAK_OUT(nak),
		.EP0_STALL_REQ_OUT(sreq), .EP_ENABLE_OUT(en), .EP_IN_PIPE_OUT(ip),
		.EP_OUT_PIPE_OUT(op));
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task chk(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task wb(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {a, 2'b00};
		dat <= {24'h000000, d};
		// Wait on ack, bounded so a dead slave cannot hang the run
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) error_cnt++;
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task wr(input logic [4:0] a, input logic [7:0] d);
		wb(1'b1, a, d);
	endtask
	task rd(input logic [4:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(q, e);
	endtask
	task settle();
		repeat (3) @(posedge clk);
	endtask
	task test_done();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		test_done();
	end
	initial begin
		rst = 1'b1;
		{cyc, stb, we} = 3'h0;
		adr = 7'h00;
		sel = 4'h1;
		dat = 32'h00000000;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		settle();
		chk({4'h0, en, nak}, 8'h0f);
		rd(5'h1e, 8'hff);
		rd(5'h11, 8'h00);
		rd(5'h16, 8'h00);
		i_host.send(7'h08, 7'h7f);
		rd(5'h11, 8'h01);
		rd(5'h16, 8'h7f);
		wr(5'h16, 8'hff);
		rd(5'h16, 8'h7f);
		wr(5'h11, 8'h00);
		rd(5'h11, 8'h01);
		wr(5'h11, 8'hc2);
		rd(5'h11, 8'h02);
		settle();
		chk({7'h00, nak}, 8'h00);
		i_host.send(7'h04, 7'h00);
		rd(5'h11, 8'h00);
		settle();
		chk({7'h00, nak}, 8'h01);
		i_host.send(7'h04, 7'h00);
		wr(5'h11, 8'h20);
		rd(5'h11, 8'h20);
		settle();
		chk({7'h00, sreq}, 8'h01);
		i_host.send(7'h02, 7'h00);
		rd(5'h11, 8'h04);
		wr(5'h11, 8'h04);
		rd(5'h11, 8'h04);
		wr(5'h11, 8'h00);
		rd(5'h11, 8'h00);
		i_host.send(7'h20, 7'h00);
		i_host.send(7'h40, 7'h00);
		rd(5'h11, 8'h10);
		wr(5'h11, 8'h80);
		rd(5'h11, 8'h00);
		wr(5'h11, 8'h0a);
		rd(5'h11, 8'h0a);
		i_host.send(7'h01, 7'h00);
		rd(5'h11, 8'h02);
		i_host.send(7'h08, 7'h08);
		rd(5'h11, 8'h01);
		wr(5'h0e, 8'h01);
		rd(5'h11, 8'h00);
		rd(5'h16, 8'h00);
		wr(5'h12, 8'h04);
		wr(5'h0e, 8'h02);
		wr(5'h12, 8'h20);
		settle();
		chk({2'h0, ip, op}, 8'h1d);
		wr(5'h1e, 8'h0d);
		rd(5'h1e, 8'hfd);
		settle();
		chk({2'h0, en, ip}, 8'h32);
		chk({5'h00, op}, 8'h04);
		wr(5'h0e, 8'h00);
		rd(5'h11, 8'h01);
		wr(5'h11, 8'h40);
		rd(5'h11, 8'h00);
		rd(5'h01, 8'h00);
		test_done();
	end
endmodule
